/* File: cpu_subset_regs.vh */
`ifndef CPU_SUBSET_REGS_VH
`define CPU_SUBSET_REGS_VH

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define OP_W 5
`define OP_DECIMAL_ADJUST 5'h00
`define OP_IRQ_BLOCK 5'h01
`define OP_DIV_S 5'h02
`define OP_DIV_U 5'h03
`define OP_DIV_SD 5'h04
`define OP_DIV_UD 5'h05
`define OP_DIV_FRAC 5'h06
`define OP_LOOP_LIT 5'h07
`define OP_LOOP_REG 5'h08
`define OP_SIGN_CHANGE_SEARCH 5'h09
`define OP_LEADING_ONE_SEARCH 5'h0A
`define OP_TRAILING_ONE_SEARCH 5'h0B
`define OP_JUMP_DIRECT 5'h0C
`define OP_JUMP_INDIRECT 5'h0D
`define OP_JUMP_LONG 5'h0E
`define OP_SHIFT_RIGHT_REG 5'h0F
`define OP_SHIFT_RIGHT_LIT 5'h10

// ----------------------------------------------------------------
// Cycle and word counts
// ----------------------------------------------------------------
`define CNT_W 5
`define CYC_SINGLE 5'h01
`define CYC_DIVIDE 5'h12
`define CYC_LOOP 5'h02
`define CYC_JUMP 5'h04
`define CYC_SFR_EXTRA 5'h01
`define WORDS_W 2
`define WORDS_ONE 2'h1
`define WORDS_TWO 2'h2
`define DIV_STEPS 5'h10

// ----------------------------------------------------------------
// Status flag layout {N, OV, Z, C}
// ----------------------------------------------------------------
`define FLAG_W 4
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_OV 2
`define FLAG_N 3
`define FLAGS_RESET 4'h0
`define MASK_NONE 4'h0
`define MASK_C 4'h1
`define MASK_NZ 4'hA
`define MASK_NZCOV 4'hF

// ----------------------------------------------------------------
// Literal fields and decimal adjust constants
// ----------------------------------------------------------------
`define LIT14_W 14
`define LIT15_W 15
`define LIT5_W 5
`define SHIFT_REG_W 4
`define BCD_LIMIT 4'h9
`define BCD_LOW_FIX 9'h006
`define BCD_HIGH_FIX 9'h060

`endif

/* File: divide_engine.v */
`include "cpu_subset_regs.vh"
`default_nettype none

module divide_engine (
   input wire clock,
   input wire rst_n,
   input wire start,
   input wire signed_mode,
   input wire wide_mode,
   input wire frac_mode,
   input wire [15:0] dividend_hi,
   input wire [15:0] dividend_lo,
   input wire [15:0] divisor,
   output wire [15:0] quotient,
   output wire [15:0] remainder,
   output wire overflow
);
   // ----------------------------------------------------------------
   // Operand magnitudes
   // ----------------------------------------------------------------
   wire [31:0] base_num;
   wire num_neg;
   wire [31:0] num_abs;
   wire [31:0] num_mag;
   wire den_neg;
   wire [15:0] den_mag;
   assign base_num = wide_mode ? {dividend_hi, dividend_lo} :
                     (signed_mode ? {{16{dividend_lo[15]}}, dividend_lo} :
                      {16'h0000, dividend_lo});
   assign num_neg = signed_mode & base_num[31];
   assign num_abs = num_neg ? (32'h00000000 - base_num) : base_num;
   // Fractional form scales the dividend to Q15
   assign num_mag = frac_mode ? {num_abs[16:0], 15'h0000} : num_abs;
   assign den_neg = signed_mode & divisor[15];
   assign den_mag = den_neg ? (16'h0000 - divisor) : divisor;

   // ----------------------------------------------------------------
   // Restoring shift-subtract loop
   // ----------------------------------------------------------------
   reg [15:0] rem_q;
   reg [15:0] quo_q;
   reg [15:0] den_q;
   reg [`CNT_W-1:0] step_q;
   reg pre_ov_q;
   reg quo_neg_q;
   reg rem_neg_q;
   reg signed_q;
   wire [16:0] trial;
   wire fits;
   assign trial = {rem_q, quo_q[15]};
   assign fits = trial >= {1'b0, den_q};

   always @(posedge clock) begin
      if (!rst_n) begin
         rem_q <= 16'h0000;
         quo_q <= 16'h0000;
         den_q <= 16'h0000;
         step_q <= 5'h00;
         pre_ov_q <= 1'b0;
         quo_neg_q <= 1'b0;
         rem_neg_q <= 1'b0;
         signed_q <= 1'b0;
      end else if (start) begin
         rem_q <= num_mag[31:16];
         quo_q <= num_mag[15:0];
         den_q <= den_mag;
         step_q <= `DIV_STEPS;
         pre_ov_q <= (den_mag == 16'h0000) | (num_mag[31:16] >= den_mag);
         quo_neg_q <= num_neg ^ den_neg;
         rem_neg_q <= num_neg;
         signed_q <= signed_mode;
      end else if (step_q != 5'h00) begin
         rem_q <= fits ? (trial[15:0] - den_q) : trial[15:0];
         quo_q <= {quo_q[14:0], fits};
         step_q <= step_q - 5'h01;
      end
   end

   // ----------------------------------------------------------------
   // Sign correction and range check
   // ----------------------------------------------------------------
   wire signed_ov;
   assign signed_ov = signed_q & quo_q[15] & ~(quo_neg_q & (quo_q == 16'h8000));
   assign quotient = quo_neg_q ? (16'h0000 - quo_q) : quo_q;
   assign remainder = rem_neg_q ? (16'h0000 - rem_q) : rem_q;
   assign overflow = pre_ov_q | signed_ov;
endmodule // divide_engine

`default_nettype wire

/* File: exec_chk.sv */
`include "cpu_subset_regs.vh"
`default_nettype none

module exec_chk (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic issue_valid,
   input wire logic [`OP_W-1:0] issue_op,
   input wire logic sfr_access,
   input wire logic ready_q,
   input wire logic done_q,
   input wire logic [`WORDS_W-1:0] words_q,
   input wire logic [`FLAG_W-1:0] flags_q,
   input wire logic jump_q
);
   // ----------------------------------------------------------------
   // Operation classes
   // ----------------------------------------------------------------
   logic [`OP_W-1:0] op_h;
   wire take = issue_valid && ready_q;
   wire single = issue_op inside {`OP_DECIMAL_ADJUST, `OP_IRQ_BLOCK, `OP_SIGN_CHANGE_SEARCH,
      `OP_LEADING_ONE_SEARCH, `OP_TRAILING_ONE_SEARCH, `OP_SHIFT_RIGHT_REG, `OP_SHIFT_RIGHT_LIT};
   wire divide = issue_op inside {[`OP_DIV_S:`OP_DIV_FRAC]};
   wire loop_op = issue_op inside {`OP_LOOP_LIT, `OP_LOOP_REG};
   wire jump_op = issue_op inside {[`OP_JUMP_DIRECT:`OP_JUMP_LONG]};
   wire two_word = op_h inside {`OP_LOOP_LIT, `OP_LOOP_REG, `OP_JUMP_DIRECT};
   wire no_flags = op_h inside {`OP_IRQ_BLOCK, `OP_LOOP_LIT, `OP_LOOP_REG,
      [`OP_JUMP_DIRECT:`OP_JUMP_LONG]};
   wire carry_only = op_h inside {`OP_DECIMAL_ADJUST, `OP_SIGN_CHANGE_SEARCH,
      `OP_LEADING_ONE_SEARCH, `OP_TRAILING_ONE_SEARCH};
   wire shift_op = op_h inside {`OP_SHIFT_RIGHT_REG, `OP_SHIFT_RIGHT_LIT};

   always_ff @(posedge clock) begin
      if (take) begin
         op_h <= issue_op;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------------------------------
   // Latency and flag checks
   // ----------------------------------------------------------------
   a_single_latency: assert property (take && single && !sfr_access |-> ##1 !done_q ##1 done_q)
      else $error("single cycle op finished at wrong time");
   a_sfr_extra: assert property (take && single && sfr_access |-> ##2 !done_q ##1 done_q)
      else $error("peripheral access did not add one cycle");
   a_divide_latency: assert property (take && divide && !sfr_access |->
         ##18 !done_q ##1 (done_q && ready_q))
      else $error("divide finished at wrong time");
   a_loop_latency: assert property (take && loop_op && !sfr_access |->
         ##2 !done_q ##1 done_q)
      else $error("loop setup finished at wrong time");
   a_jump_latency: assert property (take && jump_op && !sfr_access |->
         ##4 !done_q ##1 (done_q && jump_q))
      else $error("jump finished at wrong time");
   a_jump_with_done: assert property (jump_q |-> done_q)
      else $error("jump pulse without completion");
   a_word_count: assert property (done_q |-> words_q == (two_word ? 2'h2 : 2'h1))
      else $error("wrong word count");
   a_flags_frozen: assert property (done_q && no_flags |-> flags_q == $past(flags_q))
      else $error("flags changed by flagless op");
   a_carry_only: assert property (done_q && carry_only |->
         flags_q[3:1] == $past(flags_q[3:1]))
      else $error("search or adjust changed more than carry");
   a_shift_keeps: assert property (done_q && shift_op |->
         {flags_q[`FLAG_C], flags_q[`FLAG_OV]} ==
         $past({flags_q[`FLAG_C], flags_q[`FLAG_OV]}))
      else $error("shift changed carry or overflow");
endmodule // exec_chk

`default_nettype wire

/* File: instr_exec.v */
// Contract
// RULE_01: Decimal adjust: one word, one cycle, carry.
// RULE_02: Block interrupts literal cycles, flags untouched.
// RULE_03: 16/16 divides: 18 cycles, N Z C OV.
// RULE_04: 32/16 divides: 18 cycles, N Z C OV.
// RULE_05: Fractional divide: 18 cycles, N Z C OV.
// RULE_06: Literal loop runs body count plus one.
// RULE_07: Register loop runs body value plus one.
// RULE_08: Sign change search from MSb, carry only.
// RULE_09: Leading one search from MSb, carry only.
// RULE_10: Trailing one search from LSb, carry only.
// RULE_11: Jumps take four cycles, flags untouched.
// RULE_12: Shift right by register: N Z only.
// RULE_13: Shift right by literal: N Z only.
// RULE_14: Peripheral register access adds one cycle.
// RULE_15: Unaffected flags keep their previous values.
`include "cpu_subset_regs.vh"
`default_nettype none

module instr_exec #(
   parameter PC_W = 23
) (
   input wire clock,
   input wire rst_n,
   input wire issue_valid,
   input wire [`OP_W-1:0] issue_op,
   input wire [15:0] operand_a,
   input wire [15:0] operand_b,
   input wire [PC_W-1:0] imm,
   input wire [PC_W-1:0] instr_pc,
   input wire sfr_access,
   input wire dc_flag,
   input wire fetch_valid,
   input wire [PC_W-1:0] fetch_pc,
   output reg ready_q,
   output reg done_q,
   output reg [`WORDS_W-1:0] words_q,
   output reg [15:0] result_q,
   output reg [15:0] remainder_q,
   output reg [`FLAG_W-1:0] flags_q,
   output reg irq_blocked_q,
   output reg jump_q,
   output reg [PC_W-1:0] jump_target_q,
   output reg loop_active_q,
   output reg loop_branch_q,
   output reg [PC_W-1:0] loop_target_q
);
   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_EXEC = 2'b10;

   reg [1:0] state_q;
   reg [`OP_W-1:0] op_q;
   reg [15:0] a_q;
   reg [15:0] b_q;
   reg [PC_W-1:0] imm_q;
   reg [PC_W-1:0] pc_q;
   reg dc_q;
   reg [`CNT_W-1:0] cnt_q;
   reg [`LIT14_W-1:0] block_cnt_q;
   reg [15:0] loop_cnt_q;
   reg [PC_W-1:0] loop_end_q;

   wire take;
   assign take = issue_valid & (state_q == ST_IDLE);

   // ----------------------------------------------------------------
   // Cycle and word tables
   // ----------------------------------------------------------------
   reg [`CNT_W-1:0] base_cycles;
   reg [`WORDS_W-1:0] op_words;
   reg [`FLAG_W-1:0] op_mask;
   always @* begin
      base_cycles = `CYC_SINGLE;
      op_words = `WORDS_ONE;
      op_mask = `MASK_NONE;
      case (issue_op)
         `OP_DECIMAL_ADJUST, `OP_SIGN_CHANGE_SEARCH,
         `OP_LEADING_ONE_SEARCH, `OP_TRAILING_ONE_SEARCH: begin
            op_mask = `MASK_C; // RULE_01
         end
         `OP_IRQ_BLOCK: begin
            op_mask = `MASK_NONE; // RULE_02
         end
         `OP_DIV_S, `OP_DIV_U, `OP_DIV_SD, `OP_DIV_UD, `OP_DIV_FRAC: begin
            base_cycles = `CYC_DIVIDE; // RULE_03
            op_mask = `MASK_NZCOV; // RULE_04
         end
         `OP_LOOP_LIT, `OP_LOOP_REG: begin
            base_cycles = `CYC_LOOP; // RULE_06
            op_words = `WORDS_TWO; // RULE_07
         end
         `OP_JUMP_DIRECT: begin
            base_cycles = `CYC_JUMP; // RULE_11
            op_words = `WORDS_TWO;
         end
         `OP_JUMP_INDIRECT, `OP_JUMP_LONG: begin
            base_cycles = `CYC_JUMP; // RULE_11
         end
         `OP_SHIFT_RIGHT_REG, `OP_SHIFT_RIGHT_LIT: begin
            op_mask = `MASK_NZ; // RULE_12
         end
         default: begin
            base_cycles = `CYC_SINGLE;
         end
      endcase
   end

   reg [`FLAG_W-1:0] mask_q;
   reg [`WORDS_W-1:0] op_words_q;

   // ----------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------
   wire is_div;
   wire [15:0] div_quo;
   wire [15:0] div_rem;
   wire div_ov;
   assign is_div = (issue_op >= `OP_DIV_S) && (issue_op <= `OP_DIV_FRAC);

   divide_engine u_divide (
      .clock(clock),
      .rst_n(rst_n),
      .start(take & is_div),
      .signed_mode((issue_op == `OP_DIV_S) | (issue_op == `OP_DIV_SD) |
                   (issue_op == `OP_DIV_FRAC)),
      .wide_mode((issue_op == `OP_DIV_SD) | (issue_op == `OP_DIV_UD)),
      .frac_mode(issue_op == `OP_DIV_FRAC), // RULE_05
      .dividend_hi(operand_b),
      .dividend_lo(operand_a),
      .divisor(imm[15:0]),
      .quotient(div_quo),
      .remainder(div_rem),
      .overflow(div_ov)
   );

   // ----------------------------------------------------------------
   // Single-cycle datapath
   // ----------------------------------------------------------------
   reg [8:0] bcd_lo;
   reg [8:0] bcd_hi;
   reg [15:0] sign_pos;
   reg sign_none;
   reg [15:0] lead_pos;
   reg lead_none;
   reg [15:0] trail_pos;
   reg trail_none;
   integer i;
   always @* begin
      bcd_lo = {1'b0, a_q[7:0]};
      if ((a_q[3:0] > `BCD_LIMIT) | dc_q) begin
         bcd_lo = bcd_lo + `BCD_LOW_FIX;
      end
      bcd_hi = bcd_lo;
      if ((bcd_lo[7:4] > `BCD_LIMIT) | bcd_lo[8] | flags_q[`FLAG_C]) begin
         bcd_hi = {1'b0, bcd_lo[7:0]} + `BCD_HIGH_FIX;
      end
      sign_pos = 16'h0000;
      sign_none = 1'b1;
      lead_pos = 16'h0000;
      lead_none = 1'b1;
      trail_pos = 16'h0000;
      trail_none = 1'b1;
      for (i = 0; i < 15; i = i + 1) begin
         if (a_q[i] != a_q[15]) begin
            sign_pos = i[15:0];
            sign_none = 1'b0;
         end
      end
      for (i = 0; i < 16; i = i + 1) begin
         if (a_q[i]) begin
            lead_pos = 16'h0010 - i[15:0];
            lead_none = 1'b0;
         end
         if (a_q[15 - i]) begin
            trail_pos = 16'h0010 - i[15:0];
            trail_none = 1'b0;
         end
      end
   end

   wire [15:0] shift_reg_res;
   wire [15:0] shift_lit_res;
   assign shift_reg_res = b_q >> a_q[`SHIFT_REG_W-1:0];
   assign shift_lit_res = b_q >> imm_q[`LIT5_W-1:0];

   reg [15:0] res;
   reg [`FLAG_W-1:0] calc;
   always @* begin
      res = 16'h0000;
      calc = flags_q;
      case (op_q)
         `OP_DECIMAL_ADJUST: begin
            res = {a_q[15:8], bcd_hi[7:0]}; // RULE_01
            calc[`FLAG_C] = flags_q[`FLAG_C] | bcd_lo[8] | bcd_hi[8];
         end
         `OP_DIV_S, `OP_DIV_U, `OP_DIV_SD, `OP_DIV_UD, `OP_DIV_FRAC: begin
            res = div_quo;
            calc[`FLAG_N] = div_quo[15];
            calc[`FLAG_Z] = (div_quo == 16'h0000);
            calc[`FLAG_C] = (div_rem != 16'h0000);
            calc[`FLAG_OV] = div_ov;
         end
         `OP_SIGN_CHANGE_SEARCH: begin
            res = sign_pos; // RULE_08
            calc[`FLAG_C] = sign_none;
         end
         `OP_LEADING_ONE_SEARCH: begin
            res = lead_pos; // RULE_09
            calc[`FLAG_C] = lead_none;
         end
         `OP_TRAILING_ONE_SEARCH: begin
            res = trail_pos; // RULE_10
            calc[`FLAG_C] = trail_none;
         end
         `OP_SHIFT_RIGHT_REG, `OP_SHIFT_RIGHT_LIT: begin
            res = (op_q == `OP_SHIFT_RIGHT_REG) ? shift_reg_res : shift_lit_res; // RULE_13
            calc[`FLAG_N] = res[15];
            calc[`FLAG_Z] = (res == 16'h0000);
         end
         default: begin
            res = 16'h0000;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   wire finish;
   wire [31:0] long_target;
   wire [PC_W-1:0] loop_offset;
   assign finish = (state_q == ST_EXEC) && (cnt_q == `CYC_SINGLE);
   assign long_target = {b_q, a_q};
   assign loop_offset = {{(PC_W-16){1'b0}}, b_q};

   always @(posedge clock) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         op_q <= `OP_DECIMAL_ADJUST;
         a_q <= 16'h0000;
         b_q <= 16'h0000;
         imm_q <= {PC_W{1'b0}};
         pc_q <= {PC_W{1'b0}};
         dc_q <= 1'b0;
         cnt_q <= 5'h00;
         mask_q <= `MASK_NONE;
         op_words_q <= `WORDS_ONE;
         ready_q <= 1'b1;
         done_q <= 1'b0;
         words_q <= `WORDS_ONE;
         result_q <= 16'h0000;
         remainder_q <= 16'h0000;
         flags_q <= `FLAGS_RESET;
         jump_q <= 1'b0;
         jump_target_q <= {PC_W{1'b0}};
      end else begin
         done_q <= 1'b0;
         jump_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (take) begin
                  state_q <= ST_EXEC;
                  ready_q <= 1'b0;
                  op_q <= issue_op;
                  a_q <= operand_a;
                  b_q <= operand_b;
                  imm_q <= imm;
                  pc_q <= instr_pc;
                  dc_q <= dc_flag;
                  mask_q <= op_mask;
                  op_words_q <= op_words;
                  cnt_q <= sfr_access ? (base_cycles + `CYC_SFR_EXTRA) : base_cycles; // RULE_14
               end
            end
            ST_EXEC: begin
               cnt_q <= cnt_q - 5'h01;
               if (finish) begin
                  state_q <= ST_IDLE;
                  ready_q <= 1'b1;
                  done_q <= 1'b1;
                  words_q <= op_words_q;
                  result_q <= res;
                  remainder_q <= div_rem;
                  flags_q <= (calc & mask_q) | (flags_q & ~mask_q); // RULE_15
                  if ((op_q == `OP_JUMP_DIRECT) | (op_q == `OP_JUMP_INDIRECT) |
                      (op_q == `OP_JUMP_LONG)) begin
                     jump_q <= 1'b1; // RULE_11
                  end
                  if (op_q == `OP_JUMP_DIRECT) begin
                     jump_target_q <= imm_q;
                  end else if (op_q == `OP_JUMP_INDIRECT) begin
                     jump_target_q <= {{(PC_W-16){1'b0}}, a_q};
                  end else if (op_q == `OP_JUMP_LONG) begin
                     jump_target_q <= long_target[PC_W-1:0];
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
               ready_q <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Interrupt block counter
   // ----------------------------------------------------------------
   always @(posedge clock) begin
      if (!rst_n) begin
         block_cnt_q <= 14'h0000;
         irq_blocked_q <= 1'b0;
      end else if (finish && (op_q == `OP_IRQ_BLOCK)) begin
         block_cnt_q <= imm_q[`LIT14_W-1:0]; // RULE_02
         irq_blocked_q <= (imm_q[`LIT14_W-1:0] != 14'h0000);
      end else if (block_cnt_q != 14'h0000) begin
         block_cnt_q <= block_cnt_q - 14'h0001;
         irq_blocked_q <= (block_cnt_q != 14'h0001);
      end
   end

   // ----------------------------------------------------------------
   // Hardware loop
   // ----------------------------------------------------------------
   always @(posedge clock) begin
      if (!rst_n) begin
         loop_active_q <= 1'b0;
         loop_cnt_q <= 16'h0000;
         loop_end_q <= {PC_W{1'b0}};
         loop_branch_q <= 1'b0;
         loop_target_q <= {PC_W{1'b0}};
      end else begin
         loop_branch_q <= 1'b0;
         if (finish && ((op_q == `OP_LOOP_LIT) || (op_q == `OP_LOOP_REG))) begin
            loop_active_q <= 1'b1;
            loop_cnt_q <= (op_q == `OP_LOOP_LIT) ?
                          {1'b0, imm_q[`LIT15_W-1:0]} : a_q; // RULE_06
            loop_end_q <= pc_q + loop_offset;
            loop_target_q <= pc_q + {{(PC_W-`WORDS_W){1'b0}}, `WORDS_TWO};
         end else if (loop_active_q && fetch_valid && (fetch_pc == loop_end_q)) begin
            if (loop_cnt_q == 16'h0000) begin
               loop_active_q <= 1'b0;
            end else begin
               loop_cnt_q <= loop_cnt_q - 16'h0001; // RULE_07
               loop_branch_q <= 1'b1;
            end
         end
      end
   end
endmodule // instr_exec

`default_nettype wire

/* File: tb_top.sv */
`include "cpu_subset_regs.vh"
`default_nettype none

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
   $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rst_n, issue_valid, sfr_access, dc_flag, fetch_valid;
   logic [4:0] issue_op;
   logic [15:0] operand_a, operand_b, result_q, remainder_q;
   logic [22:0] imm, instr_pc, fetch_pc, jump_target_q, loop_target_q;
   logic ready_q, done_q, irq_blocked_q, jump_q, loop_active_q, loop_branch_q;
   logic [1:0] words_q;
   logic [3:0] flags_q, ef;
   int num_errors, checks_done, cyc;

   instr_exec dut_u (.clock, .rst_n, .issue_valid, .issue_op, .operand_a, .operand_b, .imm,
      .instr_pc, .sfr_access, .dc_flag, .fetch_valid, .fetch_pc, .ready_q, .done_q, .words_q,
      .result_q, .remainder_q, .flags_q, .irq_blocked_q, .jump_q, .jump_target_q,
      .loop_active_q, .loop_branch_q, .loop_target_q);

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic run(input logic [4:0] op, input logic [15:0] a, b, input logic [22:0] im,
         input logic special_function_register);
      @(posedge clock);
      issue_valid <= 1'b1;
      issue_op <= op;
      operand_a <= a;
      operand_b <= b;
      imm <= im;
      sfr_access <= special_function_register;
      @(posedge clock);
      issue_valid <= 1'b0;
      cyc = 0;
      #1;
      while (done_q !== 1'b1) begin
         @(posedge clock);
         #1;
         cyc++;
         if (cyc > 40) begin
            num_errors++;
            test_done();
         end
      end
   endtask

   task automatic fetch(input logic [22:0] pc, input logic br, act);
      @(posedge clock);
      fetch_valid <= 1'b1;
      fetch_pc <= pc;
      @(posedge clock);
      fetch_valid <= 1'b0;
      #1;
      `CHK(loop_branch_q, br)
      `CHK(loop_active_q, act)
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_adjust;
      int n;
      run(`OP_DECIMAL_ADJUST, 16'h55A3, 16'h0000, 23'h000000, 1'b0);
      ef = 4'h1;
      `CHK(cyc, 1)
      `CHK(result_q, 16'h5503)
      `CHK(flags_q, ef)
      `CHK(words_q, 2'h1)
      @(posedge clock);
      issue_valid <= 1'b1;
      issue_op <= `OP_DECIMAL_ADJUST;
      operand_a <= 16'h0011;
      dc_flag <= 1'b1;
      n = 0;
      repeat (8) begin
         @(posedge clock);
         #1;
         n += done_q;
      end
      `CHK(n, 4)
      @(posedge clock);
      issue_valid <= 1'b0;
      dc_flag <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      `CHK(flags_q, ef)
      `CHK(result_q, 16'h0077)
      $display("done adjust");
   endtask

   task automatic t_search;
      logic [4:0] op [4] = '{`OP_LEADING_ONE_SEARCH, `OP_TRAILING_ONE_SEARCH,
         `OP_SIGN_CHANGE_SEARCH, `OP_LEADING_ONE_SEARCH};
      logic [15:0] a [4] = '{16'h0100, 16'h0100, 16'hF0FF, 16'h0000};
      logic [15:0] r [4] = '{16'h0008, 16'h0009, 16'h000B, 16'h0000};
      for (int i = 0; i < 4; i++) begin
         run(op[i], a[i], 16'h0000, 23'h000000, i == 3);
         ef[0] = (i == 3);
         `CHK(result_q, r[i])
         `CHK(flags_q, ef)
         `CHK(cyc, 1 + (i == 3))
      end
      $display("done search");
   endtask

   task automatic t_shift;
      run(`OP_SHIFT_RIGHT_REG, 16'h0014, 16'h8000, 23'h000000, 1'b0);
      `CHK(result_q, 16'h0800)
      `CHK(flags_q, 4'h1)
      run(`OP_SHIFT_RIGHT_LIT, 16'h0000, 16'hFFFF, 23'h000010, 1'b0);
      `CHK(result_q, 16'h0000)
      `CHK(flags_q, 4'h3)
      `CHK(cyc, 1)
      $display("done shift");
   endtask

   task automatic t_divide;
      logic [4:0] op [6] = '{`OP_DIV_U, `OP_DIV_S, `OP_DIV_UD, `OP_DIV_SD, `OP_DIV_FRAC,
         `OP_DIV_U};
      logic [15:0] a [6] = '{16'h0064, 16'hFF9C, 16'h0000, 16'hFF00, 16'h2000, 16'h0064};
      logic [15:0] b [6] = '{16'h0000, 16'h0000, 16'h0001, 16'hFFFF, 16'h0000, 16'h0000};
      logic [15:0] d [6] = '{16'h0007, 16'h0007, 16'h0010, 16'h0010, 16'h4000, 16'h0007};
      logic [15:0] q [6] = '{16'h000E, 16'hFFF2, 16'h1000, 16'hFFF0, 16'h4000, 16'h000E};
      logic [15:0] r [6] = '{16'h0002, 16'hFFFE, 16'h0000, 16'h0000, 16'h0000, 16'h0002};
      logic [3:0] f [6] = '{4'h1, 4'h9, 4'h0, 4'h8, 4'h0, 4'h1};
      for (int i = 0; i < 6; i++) begin
         run(op[i], a[i], b[i], {7'h00, d[i]}, i == 5);
         `CHK(result_q, q[i])
         `CHK(remainder_q, r[i])
         `CHK(flags_q, f[i])
         `CHK(cyc, 18 + (i == 5))
      end
      ef = 4'h1;
      $display("done divide");
   endtask

   task automatic t_block;
      int n;
      run(`OP_IRQ_BLOCK, 16'h0000, 16'h0000, 23'h000005, 1'b0);
      `CHK(cyc, 1)
      `CHK(flags_q, ef)
      n = 0;
      while (irq_blocked_q === 1'b1 && n < 20) begin
         @(posedge clock);
         #1;
         n++;
      end
      `CHK(n, 5)
      run(`OP_IRQ_BLOCK, 16'h0000, 16'h0000, 23'h000000, 1'b0);
      `CHK(irq_blocked_q, 1'b0)
      $display("done block");
   endtask

   task automatic t_jump;
      logic [4:0] op [3] = '{`OP_JUMP_DIRECT, `OP_JUMP_INDIRECT, `OP_JUMP_LONG};
      logic [15:0] a [3] = '{16'h0000, 16'h1234, 16'h0000};
      logic [15:0] b [3] = '{16'h0000, 16'h0000, 16'h0001};
      logic [22:0] t [3] = '{23'h012345, 23'h001234, 23'h010000};
      for (int i = 0; i < 3; i++) begin
         run(op[i], a[i], b[i], 23'h012345, 1'b0);
         `CHK(cyc, 4)
         `CHK(jump_q, 1'b1)
         `CHK(jump_target_q, t[i])
         `CHK(words_q, (i == 0) ? 2'h2 : 2'h1)
         `CHK(flags_q, ef)
      end
      $display("done jump");
   endtask

   task automatic t_loop;
      run(`OP_LOOP_LIT, 16'h0000, 16'h0004, 23'h000001, 1'b0);
      `CHK(cyc, 2)
      `CHK(words_q, 2'h2)
      `CHK(flags_q, ef)
      fetch(23'h000103, 1'b0, 1'b1);
      fetch(23'h000104, 1'b1, 1'b1);
      `CHK(loop_target_q, 23'h000102)
      fetch(23'h000104, 1'b0, 1'b0);
      run(`OP_LOOP_REG, 16'h0001, 16'h0004, 23'h000000, 1'b0);
      `CHK(cyc, 2)
      fetch(23'h000104, 1'b1, 1'b1);
      fetch(23'h000104, 1'b0, 1'b0);
      $display("done loop");
   endtask

   // ----------------------------------------------------------------
   // Clock and main sequence
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   initial begin
      rst_n = 1'b0;
      issue_valid = 1'b0;
      issue_op = 5'h00;
      operand_a = 16'h0000;
      operand_b = 16'h0000;
      imm = 23'h000000;
      instr_pc = 23'h000100;
      sfr_access = 1'b0;
      dc_flag = 1'b0;
      fetch_valid = 1'b0;
      fetch_pc = 23'h000000;
      num_errors = 0;
      checks_done = 0;
      ef = 4'h0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      t_adjust();
      t_search();
      t_shift();
      t_divide();
      t_block();
      t_jump();
      t_loop();
      test_done();
   end
endmodule // tb_top

bind instr_exec exec_chk chk_u (.clock, .rst_n, .issue_valid, .issue_op, .sfr_access, .ready_q,
   .done_q, .words_q, .flags_q, .jump_q);

`default_nettype wire
